/* File: asdc_pkg.sv */
// shared types and constants of the amplifier state and diagnostic control
// assumes a 40 MHz system clock; all other widths are fixed here
package asdc_pkg;
	// clock rate and timing
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned RAMP_US = 2000;
	localparam int unsigned RAMP_CYC = RAMP_US * (CLK_HZ / 1_000_000);
	localparam int unsigned SCK_LOSS_NS = 1000;
	localparam int unsigned SCK_LOSS_CYC = SCK_LOSS_NS / 25;
	localparam int unsigned DIAG_CYC = 64;
	// result byte layout and index of the clearing byte
	localparam int unsigned NUM_CH = 4;
	localparam int unsigned FAULT_W = 5;
	localparam logic [1:0] LAST_BYTE = 2'h3;
	localparam logic [7:0] RES_RESET = 8'h00;
	localparam logic [2:0] RES_PAD = 3'h0;
	// operating states
	typedef enum logic [2:0] {
		ST_STANDBY,
		ST_ECO,
		ST_AMP,
		ST_TDIAG,
		ST_PDIAG
	} asdc_state_type;
	// conditions that keep the turn-on diagnostic from starting
	typedef struct packed {
		logic low_bat;
		logic high_volt;
		logic pll_unlock;
		logic thermal;
		logic hw_mute;
	} asdc_mute_type;
	// per channel fault flags, msb first as they sit in a result byte
	typedef struct packed {
		logic soft_gnd;
		logic soft_vs;
		logic hard_gnd;
		logic hard_vs;
		logic across;
	} asdc_fault_type;
endpackage

/* File: asdc_ctrl.sv */
// operating state controller and turn-on diagnostic sequencer
// assumes control bits come from i2c logic on sys_clk_i; pins are async
// What this block does
// - With the hold input low the block stays in standby at minimum current.
// - With the hold input high it enters idle, arms protection, takes cmds.
// - In idle the power outputs and analog regulator are held at zero.
// - Idle goes to amplifier mode only with amp_on_bit set and sck present.
// - In amplifier mode two mute/play bits select muted or playing.
// - An overcurrent trip while playing starts the permanent diagnostic.
// - A rising diag_enable_bit with amp_on_bit low starts turn-on diag.
// - Diagnostic commands outside the idle state are ignored.
// - Turn-on diag is blocked below 8 V supply or under any mute condition.
// - Reading result byte four clears all four result bytes.
// - The digital regulator starts as soon as the hold input is high.
// - Entering amplifier mode ramps the analog regulator up over about 2 ms.
// - Turn-on diag reports the five fault kinds separately per channel.
`timescale 1ns/1ps
module asdc_ctrl
	import asdc_pkg::*;
#(
	parameter int unsigned RAMP_CYCLES = RAMP_CYC
)
(
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic hold_i,
	input wire logic sck_i,
	input wire logic supply_8v_ok_i,
	input wire asdc_mute_type mute_cond_i,
	input wire logic ocp_trip_i,
	input wire asdc_fault_type [NUM_CH-1:0] diag_meas_i,
	input wire logic amp_on_bit_i,
	input wire logic diag_enable_bit_i,
	input wire logic [1:0] mute_play_bits_i,
	input wire logic rd_en_i,
	input wire logic [1:0] rd_sel_i,
	output logic [7:0] rd_data_o,
	output logic diag_done_o,
	output asdc_state_type state_o,
	output logic low_power_o,
	output logic short_prot_en_o,
	output logic cmd_accept_o,
	output logic out_bias_en_o,
	output logic dig_reg_en_o,
	output logic analog_reg_en_o,
	output logic analog_reg_ready_o,
	output logic play_front_o,
	output logic play_rear_o,
	output logic perm_diag_o
);
	localparam int unsigned SYNC_W = 9 + NUM_CH * FAULT_W;
	localparam int unsigned RAMP_W = $clog2(RAMP_CYCLES + 1);

	logic rst_meta_r;
	logic rst_n_r;
	logic [SYNC_W-1:0] sync_meta_r;
	logic [SYNC_W-1:0] sync_r;
	logic hold_s;
	logic sck_s;
	logic supply_ok_s;
	logic ocp_s;
	asdc_mute_type mute_s;
	asdc_fault_type [NUM_CH-1:0] meas_s;
	logic sck_d_r;
	logic [7:0] sck_gap_r;
	logic sck_present_r;
	asdc_state_type state_r;
	asdc_state_type state_nxt;
	logic diag_en_d_r;
	logic diag_start;
	logic diag_end;
	logic [7:0] diag_cnt_r;
	logic [7:0] res_r [NUM_CH];
	logic [RAMP_W-1:0] ramp_cnt_r;
	logic clear_all;

	// reset release through two flops, assertion stays asynchronous
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			rst_meta_r <= 1'b0;
			rst_n_r <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_n_r <= rst_meta_r;
		end
	end

	// two flop synchroniser for every pin input; only sync_r is read
	always_ff @(posedge sys_clk_i or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			sync_meta_r <= '0;
			sync_r <= '0;
		end
		else
		begin
			sync_meta_r <= {hold_i, sck_i, supply_8v_ok_i, mute_cond_i,
				ocp_trip_i, diag_meas_i};
			sync_r <= sync_meta_r;
		end
	end
	assign {hold_s, sck_s, supply_ok_s, mute_s, ocp_s, meas_s} = sync_r;

	// sck presence: any edge within the loss window keeps it present
	always_ff @(posedge sys_clk_i or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			sck_d_r <= 1'b0;
			sck_gap_r <= 8'(SCK_LOSS_CYC); // no edge yet, so no clock
			sck_present_r <= 1'b0;
		end
		else
		begin
			sck_d_r <= sck_s;
			if (sck_s != sck_d_r)
				sck_gap_r <= 8'h00;
			else if (sck_gap_r < 8'(SCK_LOSS_CYC))
				sck_gap_r <= sck_gap_r + 8'h01;
			sck_present_r <= (sck_gap_r < 8'(SCK_LOSS_CYC));
		end
	end

	// a diag start needs idle, amp off, good supply and no mute at all
	assign diag_start = diag_enable_bit_i && !diag_en_d_r
		&& state_r == ST_ECO && !amp_on_bit_i
		&& supply_ok_s && !(|mute_s);
	assign diag_end = state_r == ST_TDIAG && diag_cnt_r == 8'(DIAG_CYC - 1);
	assign clear_all = rd_en_i && rd_sel_i == LAST_BYTE;

	// next state; a low hold input overrides everything
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ST_STANDBY:
				if (hold_s)
					state_nxt = ST_ECO;
			ST_ECO:
				if (diag_start)
					state_nxt = ST_TDIAG;
				else if (amp_on_bit_i && sck_present_r)
					state_nxt = ST_AMP;
			ST_TDIAG:
				if (diag_end)
					state_nxt = ST_ECO;
			ST_AMP:
				if (!amp_on_bit_i)
					state_nxt = ST_ECO;
				else if ((play_front_o || play_rear_o) && ocp_s)
					state_nxt = ST_PDIAG;
			ST_PDIAG:
				if (!amp_on_bit_i)
					state_nxt = ST_ECO;
				else if (!ocp_s)
					state_nxt = ST_AMP;
			default:
				state_nxt = ST_STANDBY;
		endcase
		if (!hold_s)
			state_nxt = ST_STANDBY;
	end

	// state register and diag enable edge memory
	always_ff @(posedge sys_clk_i or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			state_r <= ST_STANDBY;
			diag_en_d_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			diag_en_d_r <= diag_enable_bit_i;
		end
	end

	// diag cycle length counter, restarts with each cycle
	always_ff @(posedge sys_clk_i or negedge rst_n_r)
	begin
		if (!rst_n_r)
			diag_cnt_r <= 8'h00;
		else if (state_r == ST_TDIAG)
			diag_cnt_r <= diag_cnt_r + 8'h01;
		else
			diag_cnt_r <= 8'h00;
	end

	// per channel result byte; a finishing cycle wins over the clear
	for (genvar ch = 0; ch < NUM_CH; ch++)
	begin : g_res
		always_ff @(posedge sys_clk_i or negedge rst_n_r)
		begin
			if (!rst_n_r)
				res_r[ch] <= RES_RESET;
			else if (diag_end)
				res_r[ch] <= {RES_PAD, meas_s[ch]};
			else if (clear_all)
				res_r[ch] <= RES_RESET;
		end
	end

	// readback and done flag; reading byte four empties the set
	always_ff @(posedge sys_clk_i or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			rd_data_o <= 8'h00;
			diag_done_o <= 1'b0;
		end
		else
		begin
			if (rd_en_i)
				rd_data_o <= res_r[rd_sel_i];
			if (diag_end)
				diag_done_o <= 1'b1;
			else if (clear_all)
				diag_done_o <= 1'b0;
		end
	end

	// analog regulator ramp; runs only in amplifier mode and permanent diag
	always_ff @(posedge sys_clk_i or negedge rst_n_r)
	begin
		if (!rst_n_r)
			ramp_cnt_r <= '0;
		else if (state_r == ST_AMP || state_r == ST_PDIAG)
		begin
			if (ramp_cnt_r < RAMP_W'(RAMP_CYCLES))
				ramp_cnt_r <= ramp_cnt_r + 1'b1;
		end
		else
			ramp_cnt_r <= '0;
	end

	// play selection follows the host bits only in amplifier mode
	always_ff @(posedge sys_clk_i or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			play_front_o <= 1'b0;
			play_rear_o <= 1'b0;
			dig_reg_en_o <= 1'b0;
		end
		else
		begin
			play_front_o <= state_r == ST_AMP && mute_play_bits_i[1];
			play_rear_o <= state_r == ST_AMP && mute_play_bits_i[0];
			dig_reg_en_o <= hold_s;
		end
	end

	// state decoded outputs, all but analog_reg_ready_o from the state flop alone
	assign state_o = state_r;
	assign low_power_o = state_r == ST_STANDBY;
	assign short_prot_en_o = state_r != ST_STANDBY;
	assign cmd_accept_o = state_r != ST_STANDBY;
	assign out_bias_en_o = state_r == ST_AMP || state_r == ST_PDIAG;
	assign analog_reg_en_o = out_bias_en_o;
	assign analog_reg_ready_o = out_bias_en_o
		&& ramp_cnt_r == RAMP_W'(RAMP_CYCLES);
	assign perm_diag_o = state_r == ST_PDIAG;

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_r);

	a_standby_hold: assert property (!hold_s |=> state_r == ST_STANDBY)
		else $error("hold low did not force standby");
	a_eco_entry: assert property ($rose(hold_s) && state_r == ST_STANDBY
		|=> state_r == ST_ECO && cmd_accept_o && short_prot_en_o)
		else $error("idle not entered with protection armed");
	a_idle_zero: assert property (state_r == ST_ECO
		|-> !out_bias_en_o && !analog_reg_en_o)
		else $error("outputs biased while idle");
	a_amp_cause: assert property ($rose(state_r == ST_AMP)
		&& $past(state_r) == ST_ECO
		|-> $past(amp_on_bit_i) && $past(sck_present_r))
		else $error("amplifier mode without amp_on and sck");
	a_play_follow: assert property (state_r == ST_AMP
		|=> play_front_o == $past(mute_play_bits_i[1])
		&& play_rear_o == $past(mute_play_bits_i[0]))
		else $error("play outputs do not follow the bits");
	a_perm_start: assert property (state_r == ST_AMP && hold_s
		&& amp_on_bit_i && ocp_s && (play_front_o || play_rear_o)
		|=> perm_diag_o)
		else $error("permanent diag not started on trip");
	a_diag_gate: assert property ($rose(state_r == ST_TDIAG)
		|-> $past(state_r) == ST_ECO && !$past(amp_on_bit_i)
		&& $past(supply_ok_s) && !(|$past(mute_s)))
		else $error("turn-on diag started while blocked");
	a_diag_hold: assert property ($rose(state_r == ST_TDIAG) && hold_s
		|-> (state_r == ST_TDIAG)[*8])
		else $error("turn-on diag cut short");
	a_db4_clear: assert property (clear_all && !diag_end
		|=> res_r[0] == RES_RESET && res_r[3] == RES_RESET
		&& !diag_done_o)
		else $error("byte four read did not clear results");
	a_dreg_on: assert property (hold_s |=> dig_reg_en_o)
		else $error("digital regulator late");
	a_ramp_slow: assert property ($rose(analog_reg_en_o)
		|-> !analog_reg_ready_o [*8])
		else $error("analog regulator ready without ramp");

	c_amp_on: cover property ($rose(state_r == ST_AMP));
	c_diag_done: cover property (diag_end);
	c_perm: cover property ($rose(perm_diag_o));
	c_clear: cover property (diag_done_o && clear_all);
endmodule

/* File: asdc_host.sv */
// host model: drives the control bits and reads diagnostic result bytes
// assumes the bench calls its tasks; all changes land on the falling edge
`timescale 1ns/1ps
module asdc_host
(
	input wire logic clk_i,
	input wire logic [7:0] rd_data_i,
	output logic amp_on_o,
	output logic diag_en_o,
	output logic [1:0] mute_play_o,
	output logic rd_en_o,
	output logic [1:0] rd_sel_o
);
	// quiet levels from time zero
	initial
	begin
		amp_on_o = 1'b0;
		diag_en_o = 1'b0;
		mute_play_o = 2'h0;
		rd_en_o = 1'b0;
		rd_sel_o = 2'h0;
	end
	// callers raise amp_on only after diag work is over
	task automatic set_amp(input logic v);
		@(negedge clk_i);
		amp_on_o = v;
	endtask
	task automatic set_mp(input logic [1:0] v);
		@(negedge clk_i);
		mute_play_o = v;
	endtask
	// a short high pulse gives one rising edge
	task automatic pulse_diag();
		@(negedge clk_i);
		diag_en_o = 1'b1;
		repeat (2) @(negedge clk_i);
		diag_en_o = 1'b0;
		@(negedge clk_i);
	endtask
	// one-cycle strobe; data taken two edges on, it stands till next read
	task automatic read_byte(input logic [1:0] sel, output logic [7:0] d);
		@(negedge clk_i);
		rd_en_o = 1'b1; // after done, bytes in order, then byte 0 again after the clear
		rd_sel_o = sel;
		@(negedge clk_i);
		rd_en_o = 1'b0;
		@(negedge clk_i);
		d = rd_data_i;
	endtask
endmodule

/* File: tb.sv */
// self-checking bench for the amplifier state and diagnostic controller
// assumes asdc_pkg, asdc_ctrl and asdc_host are compiled first
`timescale 1ns/1ps
module tb;
	import asdc_pkg::*;
	localparam int unsigned RC = 20;
	logic sys_clk_i, arst_n_i, hold_i, sck_i, sck_run, supply_ok, ocp;
	asdc_mute_type mute;
	asdc_fault_type [NUM_CH-1:0] meas;
	logic amp_on, diag_en, rd_en, done, low_pwr, prot, acc, bias;
	logic dreg, areg, ardy, pf, pr, pdiag;
	logic [1:0] mp, rd_sel;
	logic [7:0] rd_data, d;
	asdc_state_type st;
	int error_cnt, n_tests;
	asdc_ctrl #(.RAMP_CYCLES(RC)) DUT (.sys_clk_i(sys_clk_i),
		.arst_n_i(arst_n_i), .hold_i(hold_i), .sck_i(sck_i),
		.supply_8v_ok_i(supply_ok), .mute_cond_i(mute), .ocp_trip_i(ocp),
		.diag_meas_i(meas), .amp_on_bit_i(amp_on),
		.diag_enable_bit_i(diag_en), .mute_play_bits_i(mp),
		.rd_en_i(rd_en), .rd_sel_i(rd_sel), .rd_data_o(rd_data),
		.diag_done_o(done), .state_o(st), .low_power_o(low_pwr),
		.short_prot_en_o(prot), .cmd_accept_o(acc), .out_bias_en_o(bias),
		.dig_reg_en_o(dreg), .analog_reg_en_o(areg),
		.analog_reg_ready_o(ardy), .play_front_o(pf), .play_rear_o(pr),
		.perm_diag_o(pdiag));
	asdc_host host (.clk_i(sys_clk_i), .rd_data_i(rd_data),
		.amp_on_o(amp_on), .diag_en_o(diag_en), .mute_play_o(mp),
		.rd_en_o(rd_en), .rd_sel_o(rd_sel));
	// 40 MHz system clock
	initial
	begin
		sys_clk_i = 1'b0;
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end
	// audio clock, 200 ns, odd phase; stands low while not wanted
	initial
	begin
		sck_i = 1'b0;
		#7;
		forever
		begin
			#100;
			sck_i = sck_run & ~sck_i;
		end
	end
	task automatic results();
		if (error_cnt == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, g);
		n_tests++;
		if (g !== e)
		begin
			$display("FAIL %s exp %h got %h", nm, e, g);
			error_cnt++;
		end
	endtask
	// bounded wait for a state; running out ends the run
	task automatic wst(input asdc_state_type s, input int n);
		for (int i = 0; i < n && st !== s; i++)
			@(negedge sys_clk_i);
		chk("state", {5'h0, s}, {5'h0, st});
		if (st !== s)
			results();
	endtask
	initial
	begin
		arst_n_i = 1'b0;
		hold_i = 1'b0;
		sck_run = 1'b0;
		supply_ok = 1'b1;
		ocp = 1'b0;
		mute = '0;
		meas = {5'h11, 5'h0a, 5'h14, 5'h03};
		error_cnt = 0;
		n_tests = 0;
		repeat (2) @(negedge sys_clk_i);
		arst_n_i = 1'b1;
		repeat (5) @(negedge sys_clk_i);
		chk("stby", {4'h0, ST_STANDBY, 1'b1}, {4'h0, st, low_pwr});
		hold_i = 1'b1;
		wst(ST_ECO, 6);
		chk("eco", 8'h07, {5'h0, acc, prot, dreg});
		chk("eco_bias", 8'h00, {5'h0, bias, areg, low_pwr});
		// each blocker alone, then low supply alone
		for (int i = 0; i < 6; i++)
		begin
			mute = (i < 5) ? asdc_mute_type'(5'h1 << i) : '0;
			supply_ok = (i == 5) ? 1'b0 : 1'b1;
			repeat (3) @(negedge sys_clk_i);
			host.pulse_diag();
			chk("blocked", {5'h0, ST_ECO}, {5'h0, st});
		end
		supply_ok = 1'b1;
		repeat (3) @(negedge sys_clk_i);
		host.pulse_diag();
		chk("tdiag", {5'h0, ST_TDIAG}, {5'h0, st});
		host.pulse_diag(); // a restart here would overrun the bound
		wst(ST_ECO, 60);
		chk("done", 8'h01, {7'h0, done});
		for (int i = 0; i < 4; i++)
		begin
			host.read_byte(i[1:0], d);
			chk("byte", {RES_PAD, meas[i]}, d);
		end
		chk("cleared_done", 8'h00, {7'h0, done});
		host.read_byte(2'h0, d);
		chk("cleared_byte", RES_RESET, d);
		// amp_on without audio clock must not leave idle
		host.set_amp(1'b1);
		repeat (10) @(negedge sys_clk_i);
		chk("no_sck", {5'h0, ST_ECO}, {5'h0, st});
		sck_run = 1'b1;
		wst(ST_AMP, 20);
		chk("amp", 8'h06, {5'h0, bias, areg, ardy});
		repeat (RC - 2) @(negedge sys_clk_i);
		chk("ramp_early", 8'h00, {7'h0, ardy});
		repeat (4) @(negedge sys_clk_i);
		chk("ramp_done", 8'h01, {7'h0, ardy});
		host.pulse_diag();
		chk("amp_diag", {5'h0, ST_AMP}, {5'h0, st});
		for (int i = 0; i < 4; i++)
		begin
			host.set_mp(i[1:0]);
			repeat (3) @(negedge sys_clk_i);
			chk("play", {6'h0, i[1:0]}, {6'h0, pf, pr});
		end
		host.set_mp(2'h2);
		repeat (2) @(negedge sys_clk_i);
		ocp = 1'b1;
		wst(ST_PDIAG, 8);
		chk("perm", 8'h01, {7'h0, pdiag});
		ocp = 1'b0;
		wst(ST_AMP, 8);
		hold_i = 1'b0;
		wst(ST_STANDBY, 8);
		chk("stby_out", 8'h01, {6'h0, acc, low_pwr});
		results();
	end
endmodule
